// ==== reset_seq_regs.vh ====
// Register offsets, field positions, reset values and timing counts
// for the reset sequencer. Included by the sequencer module and its bench.
`ifndef RESET_SEQ_REGS_VH
`define RESET_SEQ_REGS_VH

// AXI4-Lite byte offsets
`define RS_CAUSE_OFS 4'h0
`define RS_CTRL_OFS 4'h4
`define RS_STATE_OFS 4'h8

// Reset cause register bit positions
`define RS_BIT_LOWSUP 1
`define RS_BIT_MONITOR 2
`define RS_BIT_BADADDR 3
`define RS_BIT_BADOP 4
`define RS_BIT_WDOG 5
`define RS_BIT_EXT 6
`define RS_BIT_POWERON 7

// Control register bit positions
`define RS_CTRL_STOP_OK 0
`define RS_CTRL_WDOG_EN 1

// Reset values
`define RS_CAUSE_RST 8'h80
`define RS_CTRL_RST 2'h0

// Timing counts in reference-clock cycles
`define RS_LINE_CYC 32
`define RS_HOLD_CYC 32
`define RS_SAMPLE_CYC 32
`define RS_STAB_CYC 4096
`define RS_CPU_CYC 64
`define RS_EXT_MIN_CYC 4

// Reset vector address and watchdog service address
`define RS_VECTOR_HI 16'hFFFE
`define RS_VECTOR_LO 16'hFFFF
`define RS_WDOG_ADDR 16'hFFFF

`endif

// ==== reset_sequencer_status.v ====
// Reset sequencer: gathers reset causes, drives the shared open-drain
// reset line, times oscillator stabilization and releases the CPU.
// Assumes clk_sys is the crystal reference clock, all inputs synchronous.
//
// Contract
// - Reset aborts instruction, fetch vector FFFE/FFFF
// - Reset selects reference clock divided by four
// - Line held low min time sets external flag
// - Internal reset drives line low 32 cycles
// - Hold device in reset 32 more cycles
// - Power-on: 4096-cycle stabilization, line low throughout
// - Then line released +32, CPU +64 cycles
// - Power-on sets power-on and low-supply, clears others
// - Watchdog overflow resets, sets watchdog flag
// - Write to top address clears watchdog counter
// - Low-supply holds line, stabilizes, then releases
// - Low-supply reset sets low-supply flag
// - Illegal opcode resets, sets bad-opcode flag
// - Stop with stop-allow clear is illegal opcode
// - Opcode fetch unmapped resets, sets bad-address flag
// - Data access unmapped causes no reset
// - Cause register read-only, cleared by read
// - Sample line 32 cycles after release
// - Flags accumulate until register is read
// - Monitor entry reset sets monitor flag
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_regs.vh"

module reset_sequencer_status #(
  parameter STAB_CYC = `RS_STAB_CYC,
  parameter WDOG_W = 13,
  parameter EXT_MIN_CYC = `RS_EXT_MIN_CYC
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire nrst,
  input wire clk_en,
  // Shared open-drain reset line
  input wire rst_line_in,
  output reg rst_line_out,
  output reg rst_line_oe,
  // Reset causes from the core
  input wire power_on,
  input wire supply_low,
  input wire opcode_fetch,
  input wire opcode_bad,
  input wire opcode_stop,
  input wire addr_unmapped,
  input wire monitor_force,
  input wire cpu_write,
  input wire [15:0] cpu_addr,
  // Core control
  output reg cpu_in_reset,
  output reg clocks_held,
  output reg vector_fetch,
  output reg [15:0] vector_addr,
  output reg bus_div4,
  // AXI4-Lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // Sequencer states, one-hot
  // RUN: CPU executes, causes are watched
  // STAB: oscillator settling, clocks held, line driven low
  // LINE: line driven low so outside parts reset too
  // HOLD: line free, device still in reset
  // EXT: spare code, never entered
  // VEC: one cycle of reset vector fetch
  // Power and supply events jump to STAB from any state
  // An internal cause jumps from RUN to LINE
  // An external low on the line jumps from RUN to HOLD
  // The one-hot code is readable on the state register
  // for debug; software must not rely on it in the field
  localparam [5:0] ST_RUN = 6'h01;
  localparam [5:0] ST_STAB = 6'h02;
  localparam [5:0] ST_LINE = 6'h04;
  localparam [5:0] ST_HOLD = 6'h08;
  localparam [5:0] ST_EXT = 6'h10;
  localparam [5:0] ST_VEC = 6'h20;
  // Last counter values; integer maths cut to the counter width
  // Limitation: STAB_CYC above 8192 would not fit the counter
  localparam integer STAB_LAST_I = STAB_CYC - 1;
  localparam integer LINE_LAST_I = `RS_LINE_CYC - 1;
  localparam integer HOLD_LAST_I = `RS_HOLD_CYC - 1;
  localparam integer EXT_LAST_I = EXT_MIN_CYC - 1;
  localparam [12:0] STAB_LAST = STAB_LAST_I[12:0];
  localparam [12:0] LINE_LAST = LINE_LAST_I[12:0];
  localparam [12:0] HOLD_LAST = HOLD_LAST_I[12:0];
  localparam [12:0] EXT_LAST = EXT_LAST_I[12:0];

  // Two-stage reset release; only the second stage is used
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  // Sequencer state and shared phase counter
  // One counter serves all phases; it restarts on every change
  // of state, which keeps the area small at the cost of having
  // no overlap between phases
  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [12:0] cnt_r;
  reg [12:0] cnt_nxt;
  reg [7:0] cause_r;
  reg [7:0] cause_nxt;
  reg [1:0] ctrl_r;
  reg [WDOG_W-1:0] wdog_r;
  reg [12:0] ext_cnt_r;
  reg internal_r;

  // Cause detection; data accesses to unmapped space are ignored
  // The bad-opcode and bad-address causes are qualified by the opcode
  // fetch strobe, so a data cycle on a hole in the map never starts a reset
  // Causes other than power, supply and the end-of-HOLD line sample count only while running; during a sequence they
  // would restart nothing and are dropped on purpose
  wire stop_bad = opcode_stop & ~ctrl_r[`RS_CTRL_STOP_OK];
  wire bad_op = opcode_fetch & (opcode_bad | stop_bad);
  wire bad_addr = opcode_fetch & addr_unmapped;
  wire wdog_ovf = ctrl_r[`RS_CTRL_WDOG_EN] & (&wdog_r);
  wire wdog_clr = cpu_write & (cpu_addr == `RS_WDOG_ADDR);
  wire ext_seen = (ext_cnt_r == EXT_LAST);
  wire running = (state_r == ST_RUN);
  wire int_src = running & (bad_op | bad_addr | wdog_ovf | monitor_force);

  // AXI handshakes
  // A write is taken only with address and data both offered,
  // and only when no response is pending; this gives one write
  // at a time without a separate outstanding counter
  wire aw_ok = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire ar_ok = s_axi_arvalid & ~s_axi_rvalid;
  wire rd_cause = ar_ok & (s_axi_araddr == `RS_CAUSE_OFS);

  // Sequencer next state; power and supply take priority over all
  // Timeline after an internal cause, counted from the edge that
  // leaves RUN:
  //   cycles 0..31   LINE, line driven low
  //   cycles 32..63  HOLD, line free, CPU still in reset
  //   cycle 64       VEC, vector fetch pulse
  //   cycle 65       back in RUN
  // After power or supply events STAB comes first and lasts
  // STAB_CYC cycles; the same LINE and HOLD phases then follow,
  // so the line is released 32 and the CPU 64 cycles after the
  // settling delay
  // An external reset skips LINE: the outside party already
  // holds the line, and driving it too would hide its release
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 13'h0001;
    case (state_r)
      ST_RUN: begin
        cnt_nxt = 13'h0000;
        if (int_src) begin
          state_nxt = ST_LINE;
        end else if (ext_seen) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_STAB: begin
        if (cnt_r == STAB_LAST) begin
          state_nxt = ST_LINE;
          cnt_nxt = 13'h0000;
        end
      end
      ST_LINE: begin
        if (cnt_r == LINE_LAST) begin
          state_nxt = ST_HOLD;
          cnt_nxt = 13'h0000;
        end
      end
      ST_HOLD: begin
        if (cnt_r == HOLD_LAST) begin
          state_nxt = ST_VEC;
          cnt_nxt = 13'h0000;
        end
      end
      ST_VEC: begin
        state_nxt = ST_RUN;
        cnt_nxt = 13'h0000;
      end
      default: begin
        state_nxt = ST_RUN;
        cnt_nxt = 13'h0000;
      end
    endcase
    if (power_on | supply_low) begin
      state_nxt = ST_STAB;
      cnt_nxt = 13'h0000;
    end
  end

  // Cause flags: set wins over the read clear
  // A cause in the cycle of a read stays visible for the next
  // read instead of being lost; the price is that the same
  // read may return it once more
  // Power-on is applied last so it clears every flag other than power-on and low-supply
  // Bit 0 is forced low so the spare bit always reads zero
  always @* begin
    cause_nxt = cause_r;
    if (rd_cause) begin
      cause_nxt = 8'h00;
    end
    if (running & bad_op) begin
      cause_nxt[`RS_BIT_BADOP] = 1'b1;
    end
    if (running & bad_addr) begin
      cause_nxt[`RS_BIT_BADADDR] = 1'b1;
    end
    if (running & wdog_ovf) begin
      cause_nxt[`RS_BIT_WDOG] = 1'b1;
    end
    if (running & monitor_force) begin
      cause_nxt[`RS_BIT_MONITOR] = 1'b1;
    end
    if (running & ext_seen & ~int_src) begin
      cause_nxt[`RS_BIT_EXT] = 1'b1;
    end
    // Sample line once hold time elapses after an internal release
    if (state_r == ST_HOLD && cnt_r == HOLD_LAST && internal_r && !rst_line_in) begin
      cause_nxt[`RS_BIT_EXT] = 1'b1;
    end
    if (supply_low) begin
      cause_nxt[`RS_BIT_LOWSUP] = 1'b1;
    end
    if (power_on) begin
      cause_nxt = 8'h00;
      cause_nxt[`RS_BIT_POWERON] = 1'b1;
      cause_nxt[`RS_BIT_LOWSUP] = 1'b1;
    end
    cause_nxt[0] = 1'b0;
  end

  // State, flags, counters; accumulation until read
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_STAB;
      cnt_r <= 13'h0000;
      cause_r <= `RS_CAUSE_RST;
      ctrl_r <= `RS_CTRL_RST;
      wdog_r <= {WDOG_W{1'b0}};
      ext_cnt_r <= 13'h0000;
      internal_r <= 1'b1;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cause_r <= cause_nxt;
      if (state_nxt == ST_STAB || (running && int_src)) begin
        internal_r <= 1'b1;
      end else if (running && ext_seen) begin
        internal_r <= 1'b0;
      end
      // Watchdog runs only while the CPU runs
      // It counts even while disabled, but only the enable lets
      // the all-ones value start a reset; a service write clears
      // it whether or not the watchdog is enabled
      if (!running || wdog_clr || wdog_ovf) begin
        wdog_r <= {WDOG_W{1'b0}};
      end else begin
        wdog_r <= wdog_r + {{(WDOG_W-1){1'b0}}, 1'b1};
      end
      // Low-time filter on the external line, only while running
      if (!running || rst_line_in || rst_line_oe) begin
        ext_cnt_r <= 13'h0000;
      end else if (!ext_seen) begin
        ext_cnt_r <= ext_cnt_r + 13'h0001;
      end
      if (aw_ok && s_axi_awaddr == `RS_CTRL_OFS && s_axi_wstrb[0]) begin
        ctrl_r <= s_axi_wdata[1:0];
      end
    end
  end

  // Registered outputs toward the pin and the core
  // All but rst_line_out, vector_addr and bus_div4, which stays set, are decoded from the next state so they change on the
  // same edge as the state, with no extra cycle of lag
  // The line is open drain: the data output stays low and only
  // the enable decides whether the line is pulled
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_line_out <= 1'b0;
      rst_line_oe <= 1'b1;
      cpu_in_reset <= 1'b1;
      clocks_held <= 1'b1;
      vector_fetch <= 1'b0;
      vector_addr <= `RS_VECTOR_HI;
      bus_div4 <= 1'b1;
    end else if (clk_en) begin
      rst_line_out <= 1'b0;
      rst_line_oe <= (state_nxt == ST_STAB) || (state_nxt == ST_LINE);
      cpu_in_reset <= (state_nxt != ST_RUN);
      clocks_held <= (state_nxt == ST_STAB);
      vector_fetch <= (state_nxt == ST_VEC);
      vector_addr <= `RS_VECTOR_HI;
      if (state_nxt != ST_RUN) begin
        bus_div4 <= 1'b1;
      end
    end
  end

  // AXI4-Lite slave: single-cycle accept, response next cycle
  // Map: cause at 0x0 read only and cleared by read,
  // control at 0x4, state at 0x8 read only
  // Writes to read-only or unmapped offsets answer SLVERR and
  // change nothing; unmapped reads answer SLVERR with zero data
  // Readies pulse for one cycle; valids stand until taken
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end else if (clk_en) begin
      s_axi_awready <= aw_ok & ~s_axi_awready;
      s_axi_wready <= aw_ok & ~s_axi_awready;
      if (aw_ok && !s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        // Cause register is read-only; writes to it get SLVERR
        s_axi_bresp <= (s_axi_awaddr == `RS_CTRL_OFS) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ar_ok & ~s_axi_arready;
      if (ar_ok && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `RS_CAUSE_OFS: s_axi_rdata <= {24'h000000, cause_r};
          `RS_CTRL_OFS: s_axi_rdata <= {30'h0, ctrl_r};
          `RS_STATE_OFS: s_axi_rdata <= {26'h0, state_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== reset_sequencer_status_props.sv ====
// Checker for the reset sequencer's core-side timing.
// Assumes the bind below; sees only top-level ports.
`timescale 1ns/1ps
`default_nettype none
module reset_seq_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Watched ports
  input wire logic rst_line_out,
  input wire logic rst_line_oe,
  input wire logic opcode_fetch,
  input wire logic opcode_bad,
  input wire logic addr_unmapped,
  input wire logic cpu_in_reset,
  input wire logic clocks_held,
  input wire logic vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic bus_div4
);
  // One domain, so one clock and disable for all
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  vec_addr_a: assert property (vector_fetch |-> vector_addr == 16'hFFFE)
    else $error("vector address wrong");
  vec_pulse_a: assert property (vector_fetch |=> !vector_fetch && !cpu_in_reset)
    else $error("vector pulse not single");
  bus_div_a: assert property (cpu_in_reset |-> bus_div4)
    else $error("bus divider not set in reset");
  line_low_a: assert property (rst_line_oe |-> !rst_line_out)
    else $error("line driven high");
  stab_hold_a: assert property (clocks_held |-> rst_line_oe && cpu_in_reset)
    else $error("line free during stabilization");
  line_len_a: assert property ($fell(clocks_held) |-> rst_line_oe [*8] ##[20:28] !rst_line_oe)
    else $error("line release time wrong");
  hold_len_a: assert property ($fell(rst_line_oe) |-> !vector_fetch [*8] ##[20:28] vector_fetch)
    else $error("hold time wrong");
  bad_op_a: assert property (opcode_fetch && opcode_bad && !cpu_in_reset |-> ##[1:3] rst_line_oe)
    else $error("bad opcode ignored");
  bad_fetch_a: assert property (opcode_fetch && addr_unmapped && !cpu_in_reset |-> ##[1:3] rst_line_oe)
    else $error("bad fetch ignored");
endmodule
bind reset_sequencer_status reset_seq_props u_props (.clk_sys(clk_sys), .nrst(nrst),
  .rst_line_out(rst_line_out), .rst_line_oe(rst_line_oe), .opcode_fetch(opcode_fetch),
  .opcode_bad(opcode_bad), .addr_unmapped(addr_unmapped), .cpu_in_reset(cpu_in_reset),
  .clocks_held(clocks_held), .vector_fetch(vector_fetch), .vector_addr(vector_addr),
  .bus_div4(bus_div4));
`default_nettype wire

// ==== reset_line_partner.sv ====
// Outside device sharing the open-drain reset line.
// Assumes a pull-up; the bench commands how long it pulls low.
`timescale 1ns/1ps
`default_nettype none
module reset_line_partner (
  // Clock
  input wire logic clk_sys,
  // Command from the bench
  input wire logic go,
  input wire logic [7:0] len,
  // Device pull-down and resolved level
  input wire logic dev_oe,
  output logic line_lvl
);
  logic [7:0] cnt_r = 8'h00;
  // Low time counter; len must exceed the minimum low time
  always @(posedge clk_sys) begin
    if (go) cnt_r <= len;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
  end
  // Any puller wins over the pull-up
  assign line_lvl = !(dev_oe || cnt_r != 8'h00);
endmodule
`default_nettype wire

// ==== tb_reset_sequencer_status.sv ====
// Self-checking bench for the reset sequencer.
// Assumes the register header and the line partner model.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_regs.vh"
module tb_reset_sequencer_status;
  logic clk_sys = 0, nrst = 0, lvl, go = 0, pw = 1, sl = 0, of = 0, ob = 0, os = 0;
  logic au = 0, mf = 0, cw = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, ce = 1;
  logic awr, wr, bv, arr, rv, oe, ro, cir, ch, vf, bd;
  logic [1:0] br, rr;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [7:0] ln = 8'h00;
  logic [15:0] ca = 16'h0000, va;
  logic [31:0] wd = 32'h0, rd, rdat;
  int errors = 0, checks_done = 0, seed = 32'h7B5D9297, i;
  reset_sequencer_status #(.STAB_CYC(64)) uut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(ce),
    .rst_line_in(lvl), .rst_line_out(ro), .rst_line_oe(oe), .power_on(pw), .supply_low(sl),
    .opcode_fetch(of), .opcode_bad(ob), .opcode_stop(os), .addr_unmapped(au),
    .monitor_force(mf), .cpu_write(cw), .cpu_addr(ca), .cpu_in_reset(cir),
    .clocks_held(ch), .vector_fetch(vf), .vector_addr(va), .bus_div4(bd),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre));
  reset_line_partner peer (.clk_sys(clk_sys), .go(go), .len(ln), .dev_oe(oe), .line_lvl(lvl));
  // Clock and hang guard
  initial forever #2 clk_sys = ~clk_sys;
  initial begin
    #400000;
    errors++;
    tally_and_finish;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function logic [31:0] fl(input int a, input int b);
    fl = (32'h1 << a) | (32'h1 << b);
  endfunction
  // Write: address and data offered together, each dropped once taken
  task aw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    while (n < 50) begin
      @(posedge clk_sys);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) begin chk(br, er); n = 99; end
    end
    bre <= 1'b0;
    @(posedge clk_sys);
    chk(n, 99);
  endtask
  task ar(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    while (n < 50) begin
      @(posedge clk_sys);
      n++;
      if (arr) arv <= 1'b0;
      if (rv) begin d = rdat; chk(rr, er); n = 99; end
    end
    rre <= 1'b0;
    @(posedge clk_sys);
    chk(n, 99);
  endtask
  // Bounded wait for the reset vector pulse
  task wv_t;
    int n;
    n = 0;
    while (vf !== 1'b1 && n < 20000) begin @(posedge clk_sys); n++; end
    chk(vf, 1);
    chk(va, 16'hFFFE);
    @(posedge clk_sys);
  endtask
  task fire(input logic [3:0] k);
    of <= |k[2:0]; ob <= k[0]; os <= k[1]; au <= k[2]; mf <= k[3];
    @(posedge clk_sys);
    of <= 0; ob <= 0; os <= 0; au <= 0; mf <= 0;
  endtask
  task pull(input logic [7:0] n);
    ln <= n; go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pw <= 1'b0;
    chk(ch, 1);
    wv_t;
    ar(`RS_CAUSE_OFS, 2'h0, rd); chk(rd, fl(`RS_BIT_POWERON, `RS_BIT_LOWSUP));
    ar(`RS_CAUSE_OFS, 2'h0, rd); chk(rd, 0);
    aw(`RS_CAUSE_OFS, 32'hFF, 2'h2);
    ar(4'hC, 2'h2, rd); chk(rd, 0);
    // Random data traffic, unmapped data accesses included
    repeat (200) begin
      @(posedge clk_sys);
      au <= $random(seed); ca <= $random(seed); cw <= $random(seed);
      chk(cir, 0);
    end
    au <= 0; cw <= 0;
    @(posedge clk_sys);
    for (i = 0; i < 4; i++) begin fire(4'h1 << i); wv_t; end
    ar(`RS_CAUSE_OFS, 2'h0, rd);
    chk(rd, fl(`RS_BIT_BADOP, `RS_BIT_BADADDR) | fl(`RS_BIT_MONITOR, `RS_BIT_BADOP));
    aw(`RS_CTRL_OFS, 32'h1, 2'h0);
    fire(4'h2); repeat (5) @(posedge clk_sys); chk(cir, 0);
    pull(8'd8); wv_t;
    ar(`RS_CAUSE_OFS, 2'h0, rd); chk(rd, fl(`RS_BIT_EXT, `RS_BIT_EXT));
    fire(4'h1); pull(8'd80); repeat (300) @(posedge clk_sys);
    ar(`RS_CAUSE_OFS, 2'h0, rd); chk(rd, fl(`RS_BIT_BADOP, `RS_BIT_EXT));
    // Clock enable low freezes the sequencer despite a low supply
    ce <= 1'b0; sl <= 1'b1; repeat (20) @(posedge clk_sys);
    chk(cir, 0);
    chk(oe, 0);
    ce <= 1'b1;
    repeat (50) @(posedge clk_sys); chk(oe, 1);
    sl <= 1'b0; wv_t;
    ar(`RS_CAUSE_OFS, 2'h0, rd); chk(rd, fl(`RS_BIT_LOWSUP, `RS_BIT_LOWSUP));
    aw(`RS_CTRL_OFS, 32'h2, 2'h0);
    repeat (40) begin
      repeat (250) @(posedge clk_sys);
      cw <= 1'b1; ca <= 16'hFFFF;
      @(posedge clk_sys);
      cw <= 1'b0;
    end
    chk(cir, 0);
    wv_t; ar(`RS_CAUSE_OFS, 2'h0, rd); chk(rd, fl(`RS_BIT_WDOG, `RS_BIT_WDOG));
    tally_and_finish;
  end
endmodule
`default_nettype wire
